/* common/col_slave_defines.vh */
/*
 * Constants for the two-wire column driver command slave.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef COL_SLAVE_DEFINES_VH
`define COL_SLAVE_DEFINES_VH
// Command byte fields
`define CMD_CONT_BIT 7
`define CMD_RAM_ACCESS_PFX 3'h7
`define CMD_START_BANK_PFX 5'h1f
`define CMD_DEV_SEL_PFX 3'h6
`define CMD_MODE_NOT_ALLOWED 2'h3
`define COL_MAX 6'h27
// Reset values
`define MODE_RST 2'h0
`define BANK_RST 2'h0
`define COL_RST 6'h00
`define SUBADDR_RST 4'h0
// Slave address, arbitrary neutral default (bits 7..1)
`define SLAVE_ADDR 7'h3c
// Fifo shape
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

/* hw/byte_fifo.v */
/*
 * Synchronous FIFO with valid/ready on both sides; read data registered.
 * Assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/1ns
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire [WIDTH-1:0] in_data_i,
    input wire in_valid_i,
    output wire in_ready_o,
    output reg [WIDTH-1:0] out_data_o,
    output reg out_valid_o,
    input wire out_ready_i
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wptr_r;
    reg [AW-1:0] rptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;
    wire store_empty;
    wire [AW+1:0] level;

    ////////////////////////////////////////////////////////////////
    // Flags; the output register counts toward the depth, so at most DEPTH words
    assign store_empty = (count_r == {(AW+1){1'b0}});
    assign level = {1'b0, count_r} + {{(AW+1){1'b0}}, out_valid_o};
    assign in_ready_o = (level < DEPTH[AW+1:0]);
    assign push = in_valid_i && in_ready_o;
    assign pop = !store_empty && (!out_valid_o || out_ready_i);

    // Storage and pointers
    always @(posedge sys_clk_i) begin
        if (push) begin
            mem_r[wptr_r] <= in_data_i;
        end
        if (!nrst_i) begin
            wptr_r <= {AW{1'b0}};
            rptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
            out_valid_o <= 1'b0;
            out_data_o <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wptr_r <= wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= rptr_r + 1'b1;
                out_data_o <= mem_r[rptr_r];
                out_valid_o <= 1'b1;
            end else if (out_ready_i) begin
                out_valid_o <= 1'b0;
            end
            count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

/* hw/col_cmd_slave.v */
/*
 * Two-wire bus slave front end of a display column driver: start/stop
 * detection, bit shifting, acknowledge, command decode, data stream FIFO.
 * Assumes scl/sda arrive asynchronously and the system clock is far faster.
 */
// Notes on behaviour
// - Memory-access command sets mode; 11 refused
// - Memory-access copies low two bits to bank
// - Column load copies low six bits; values above 39 are ignored and leave the pointer unchanged
// - One bit per clock; sda stable high
// - Sda fall/rise with scl high: start/stop
// - Eight bits then one acknowledge slot
// - No limit on bytes per transfer
// - Transmitter releases sda during acknowledge
// - Acknowledge every received byte when addressed; data bytes are left unacknowledged while the FIFO is full
// - Acknowledger holds sda low through clock high
// - No acknowledge ends read; sda released
// - Top command bit is continuation flag
// - Prefix 11111 is start-bank command
// - Column pointer advances as each display byte is loaded for sending or accepted into the FIFO; a refused byte leaves it
`timescale 1ns/1ns
`include "col_slave_defines.vh"
module col_cmd_slave (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output reg sda_oe_o,
    output reg [1:0] access_mode_o,
    output reg [1:0] bank_select_o,
    output reg [5:0] column_pointer_o,
    output reg [1:0] top_bank_o,
    output reg [3:0] subaddr_o,
    output reg busy_o,
    output wire [7:0] wr_data_o,
    output wire wr_valid_o,
    input wire wr_ready_i,
    input wire [7:0] rd_data_i,
    output reg rd_req_o
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_CMD = 3'h2;
    localparam ST_WDATA = 3'h3;
    localparam ST_RDATA = 3'h4;

    reg [1:0] scl_s;
    reg [1:0] sda_s;
    reg scl_d_r;
    reg sda_d_r;
    reg [2:0] state_r;
    reg [7:0] shift_r;
    reg [3:0] bitcnt_r;
    reg ack_phase_r;
    reg rd_mode_r;
    reg master_nak_r;
    reg fifo_push_r;
    reg [7:0] fifo_in_r;
    wire fifo_ready;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;

    ////////////////////////////////////////////////////////////////
    // Sda is open drain: only ever driven low
    assign sda_o = 1'b0;

    // Two-flop synchronisers, then edge history from second stage
    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], scl_i};
            sda_s <= {sda_s[0], sda_i};
            scl_d_r <= scl_s[1];
            sda_d_r <= sda_s[1];
        end
    end

    // Bus conditions; sda change while scl high is control
    assign scl_rise = scl_s[1] && !scl_d_r;
    assign scl_fall = !scl_s[1] && scl_d_r;
    assign start_det = scl_s[1] && scl_d_r && sda_d_r && !sda_s[1];
    assign stop_det = scl_s[1] && scl_d_r && !sda_d_r && sda_s[1];

    ////////////////////////////////////////////////////////////////
    // Command decode helpers
    function is_ram_access;
        input [7:0] b;
        begin
            is_ram_access = (b[6:4] == `CMD_RAM_ACCESS_PFX)
                && (b[3:2] != `CMD_MODE_NOT_ALLOWED);
        end
    endfunction

    function is_start_bank;
        input [7:0] b;
        begin
            is_start_bank = (b[6:2] == `CMD_START_BANK_PFX);
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // Byte stream FIFO toward the display memory
    byte_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .in_data_i(fifo_in_r),
        .in_valid_i(fifo_push_r),
        .in_ready_o(fifo_ready),
        .out_data_o(wr_data_o),
        .out_valid_o(wr_valid_o),
        .out_ready_i(wr_ready_i)
    );

    ////////////////////////////////////////////////////////////////
    // Protocol engine
    always @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state_r <= ST_IDLE;
            shift_r <= 8'h00;
            bitcnt_r <= 4'h0;
            ack_phase_r <= 1'b0;
            rd_mode_r <= 1'b0;
            master_nak_r <= 1'b0;
            sda_oe_o <= 1'b0;
            fifo_push_r <= 1'b0;
            fifo_in_r <= 8'h00;
            rd_req_o <= 1'b0;
            busy_o <= 1'b0;
            access_mode_o <= `MODE_RST;
            bank_select_o <= `BANK_RST;
            column_pointer_o <= `COL_RST;
            top_bank_o <= `BANK_RST;
            subaddr_o <= `SUBADDR_RST;
        end else begin
            fifo_push_r <= 1'b0;
            rd_req_o <= 1'b0;
            if (start_det) begin
                // Start only counts from an idle or ongoing bus
                state_r <= ST_ADDR;
                bitcnt_r <= 4'h0;
                ack_phase_r <= 1'b0;
                // Every frame opens with an address write, whatever came before
                rd_mode_r <= 1'b0;
                sda_oe_o <= 1'b0;
                busy_o <= 1'b1;
            end else if (stop_det) begin
                state_r <= ST_IDLE;
                sda_oe_o <= 1'b0;
                busy_o <= 1'b0;
            end else if (state_r != ST_IDLE) begin
                if (scl_rise && !ack_phase_r) begin
                    // Sample one bit per clock pulse
                    shift_r <= {shift_r[6:0], sda_s[1]};
                    bitcnt_r <= bitcnt_r + 4'h1;
                end else if (scl_rise && ack_phase_r && rd_mode_r) begin
                    master_nak_r <= sda_s[1];
                end else if (scl_fall && !ack_phase_r && bitcnt_r == 4'h8) begin
                    // Eighth bit done: enter acknowledge slot
                    ack_phase_r <= 1'b1;
                    bitcnt_r <= 4'h0;
                    if (rd_mode_r) begin
                        sda_oe_o <= 1'b0;
                    end else begin
                        case (state_r)
                            ST_ADDR: begin
                                if (shift_r[7:1] == `SLAVE_ADDR) begin
                                    sda_oe_o <= 1'b1;
                                    rd_mode_r <= shift_r[0];
                                    state_r <= shift_r[0] ? ST_RDATA : ST_CMD;
                                    if (shift_r[0]) begin
                                        rd_req_o <= 1'b1;
                                    end
                                end else begin
                                    state_r <= ST_IDLE;
                                end
                            end
                            ST_CMD: begin
                                sda_oe_o <= 1'b1;
                                if (!shift_r[`CMD_CONT_BIT]) begin
                                    state_r <= ST_WDATA;
                                end
                                if (is_start_bank(shift_r)) begin
                                    top_bank_o <= shift_r[1:0];
                                end else if (is_ram_access(shift_r)) begin
                                    access_mode_o <= shift_r[3:2];
                                    bank_select_o <= shift_r[1:0];
                                end else if (!shift_r[6]
                                    && shift_r[5:0] <= `COL_MAX) begin
                                    column_pointer_o <= shift_r[5:0];
                                end else if (shift_r[6:4] == `CMD_DEV_SEL_PFX) begin
                                    subaddr_o <= shift_r[3:0];
                                end
                            end
                            ST_WDATA: begin
                                // Ack while FIFO has room; stream is unbounded
                                sda_oe_o <= fifo_ready;
                                fifo_push_r <= fifo_ready;
                                fifo_in_r <= shift_r;
                                if (fifo_ready) begin
                                    column_pointer_o <= (column_pointer_o == `COL_MAX)
                                        ? `COL_RST : column_pointer_o + 6'h01;
                                end
                            end
                            default: begin
                                state_r <= ST_IDLE;
                            end
                        endcase
                    end
                end else if (scl_fall && ack_phase_r) begin
                    // Leave acknowledge slot, held low across high phase
                    ack_phase_r <= 1'b0;
                    if (rd_mode_r) begin
                        if (master_nak_r) begin
                            sda_oe_o <= 1'b0;
                            state_r <= ST_IDLE;
                        end else begin
                            shift_r <= rd_data_i;
                            sda_oe_o <= !rd_data_i[7];
                            // Count from zero so the slot follows the eighth bit
                            bitcnt_r <= 4'h0;
                            rd_req_o <= 1'b1;
                            column_pointer_o <= (column_pointer_o == `COL_MAX)
                                ? `COL_RST : column_pointer_o + 6'h01;
                        end
                    end else begin
                        sda_oe_o <= 1'b0;
                    end
                end else if (rd_mode_r && scl_fall && !ack_phase_r) begin
                    // Transmit next bit, msb first
                    if (bitcnt_r == 4'h0) begin
                        bitcnt_r <= 4'h1;
                    end
                    sda_oe_o <= !shift_r[7];
                end
            end
        end
    end
endmodule

/* sim/col_cmd_slave_asserts.sv */
/* Port checker for col_cmd_slave.
   Assumes a bind onto the slave; sync reset, active low. */
`timescale 1ns/1ns
module col_cmd_slave_asserts (
    input wire sys_clk_i,
    input wire nrst_i,
    input wire scl_i,
    input wire sda_i,
    input wire sda_oe_o,
    input wire [1:0] access_mode_o,
    input wire [5:0] column_pointer_o,
    input wire busy_o,
    input wire [7:0] wr_data_o,
    input wire wr_valid_o,
    input wire wr_ready_i,
    input wire rd_req_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////
    // Bus conditions at the raw pins
    sequence s_start;
        scl_i && $past(scl_i) && $fell(sda_i);
    endsequence
    sequence s_stop;
        scl_i && $past(scl_i) && $rose(sda_i);
    endsequence
    a_start_busy: assert property (s_start |-> ##[1:8] busy_o)
        else $error("busy missing after start");
    a_stop_idle: assert property (s_stop |-> ##[1:8] !busy_o)
        else $error("busy stuck after stop");
    a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("sda drive changed with scl high");
    a_ack_hold: assert property (sda_oe_o && $rose(scl_i) |-> sda_oe_o [*5])
        else $error("acknowledge dropped in high phase");
    a_col_range: assert property (column_pointer_o <= 6'h27)
        else $error("column pointer above 39");
    a_mode_legal: assert property (access_mode_o != 2'h3)
        else $error("access mode 3 taken");
    a_fifo_hold: assert property (wr_valid_o && !wr_ready_i |=>
        wr_valid_o && $stable(wr_data_o))
        else $error("fifo output dropped while stalled");
    a_req_pulse: assert property (rd_req_o |=> !rd_req_o)
        else $error("read request longer than a cycle");
    a_idle_float: assert property (!busy_o |-> !sda_oe_o)
        else $error("sda driven while bus idle");
endmodule
bind col_cmd_slave col_cmd_slave_asserts u_chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(sda_oe_o), .access_mode_o(access_mode_o),
    .column_pointer_o(column_pointer_o), .busy_o(busy_o), .wr_data_o(wr_data_o),
    .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .rd_req_o(rd_req_o));

/* sim/column_driver_bus_command_slave_test.sv */
/* Self-checking bench for col_cmd_slave with a master model.
   Assumes the slave address of the defines header. */
`timescale 1ns/1ns
`include "col_slave_defines.vh"
module column_driver_bus_command_slave_test;
    logic clk, nrst, wr_ready, sink_hold;
    logic [7:0] rd_data;
    wire scl, m_oe, s_oe, busy, wr_valid, rd_req;
    wire [1:0] mode, bank, top_bank;
    wire [5:0] column;
    wire [3:0] subaddr;
    wire [7:0] wr_data;
    wire sda = ~(m_oe | s_oe);
    logic [7:0] rxq[$];
    int errors, n_compared;
    col_cmd_slave dut (.sys_clk_i(clk), .nrst_i(nrst), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe_o(s_oe), .access_mode_o(mode), .bank_select_o(bank),
        .column_pointer_o(column), .top_bank_o(top_bank), .subaddr_o(subaddr), .busy_o(busy),
        .wr_data_o(wr_data), .wr_valid_o(wr_valid), .wr_ready_i(wr_ready),
        .rd_data_i(rd_data), .rd_req_o(rd_req));
    i2c_master_model m (.sys_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Sink stalls when held, else takes every other cycle
    always @(posedge clk) begin
        wr_ready <= ~sink_hold & ~wr_ready;
        if (wr_valid && wr_ready)
            rxq.push_back(wr_data);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic xfer_open(input logic rw);
        logic a;
        m.start;
        m.wr_byte({`SLAVE_ADDR, rw}, a);
        chk(8'(busy), 8'h1);
        chk(8'(a), 8'h1);
    endtask
    task automatic xfer_close;
        m.stop;
        repeat (8) @(posedge clk);
        chk(8'(busy), 8'h0);
    endtask
    ////////////////////////////////////////
    // Device select, a column load, an out of range load, then data that looks like a command
    task automatic t_cmds;
        logic a;
        xfer_open(1'b0);
        m.wr_byte(8'he9, a);
        chk(8'(subaddr), 8'h09);
        m.wr_byte(8'ha7, a);
        chk(8'(column), 8'h27);
        m.wr_byte(8'h28, a);
        chk(8'(column), 8'h27);
        m.wr_byte(8'he6, a);
        repeat (10) @(posedge clk);
        chk(8'(mode), 8'h0);
        chk(rxq.pop_front(), 8'he6);
        chk(8'(column), 8'h0);
        xfer_close;
    endtask
    // Every access mode code with a distinct bank
    task automatic t_access;
        logic a;
        logic [1:0] em, eb;
        em = 2'h0;
        eb = 2'h0;
        xfer_open(1'b0);
        for (int g = 0; g < 4; g++) begin
            m.wr_byte({4'hf, 2'(g), 2'(g) ^ 2'h1}, a);
            if (g < 3) begin
                em = 2'(g);
                eb = 2'(g) ^ 2'h1;
            end
            chk(8'(mode), 8'(em));
            chk(8'(bank), 8'(eb));
        end
        chk(8'(top_bank), 8'h2);
        xfer_close;
    endtask
    // Foreign address is left unacknowledged
    task automatic t_addr_miss;
        logic a;
        m.start;
        m.wr_byte({`SLAVE_ADDR ^ 7'h01, 1'b0}, a);
        chk(8'(a), 8'h0);
        m.wr_byte(8'h55, a);
        chk(8'(a), 8'h0);
        xfer_close;
    endtask
    // Fill the stalled buffer until it refuses, then drain it
    task automatic t_fill;
        logic a;
        sink_hold = 1'b1;
        xfer_open(1'b0);
        m.wr_byte(8'h00, a);
        for (int i = 0; i < 18; i++) begin
            m.wr_byte(8'h40 + 8'(i), a);
            chk(8'(a), 8'(i < `FIFO_DEPTH));
        end
        chk(8'(a), 8'h0);
        xfer_close;
        sink_hold = 1'b0;
        repeat (100) @(posedge clk);
        chk(8'(rxq.size()), 8'(`FIFO_DEPTH));
        for (int k = 0; k < `FIFO_DEPTH; k++)
            chk(rxq.pop_front(), 8'h40 + 8'(k));
    endtask
    // Two byte read ending with no acknowledge
    task automatic t_read;
        logic [7:0] d;
        rd_data <= 8'ha5;
        xfer_open(1'b1);
        m.rd_byte(1'b0, d);
        chk(d, 8'ha5);
        m.rd_byte(1'b1, d);
        chk(d, 8'ha5);
        chk(8'(column), 8'h12);
        repeat (6) @(posedge clk);
        chk(8'(s_oe), 8'h0);
        xfer_close;
    endtask
    initial begin
        nrst = 1'b0;
        rd_data = 8'h00;
        wr_ready = 1'b0;
        sink_hold = 1'b0;
        errors = 0;
        n_compared = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_cmds;
        t_access;
        t_addr_miss;
        t_fill;
        t_read;
        test_done;
    end
    // Watchdog: about ten times the expected run
    initial begin
        #400000;
        errors++;
        test_done;
    end
endmodule

/* sim/i2c_master_model.sv */
/* Two-wire bus master model; bit period 125 ns on system clock edges.
   Assumes a pull-up on sda; sda_oe_o high pulls the line low. */
`timescale 1ns/1ns
module i2c_master_model (
    input wire sys_clk_i,
    input wire sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    realtime t_due;
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
        t_due = 0.0;
    end
    // Quarter of a 125 ns bus clock period, rounded up to system clock edges
    task automatic qtr;
        t_due = t_due + 31.25;
        @(posedge sys_clk_i);
        while ($realtime < t_due)
            @(posedge sys_clk_i);
    endtask
    // Start from an idle bus: data falls with clock high
    task automatic start;
        t_due = $realtime;
        qtr;
        sda_oe_o <= 1'b1;
        qtr;
        scl_o <= 1'b0;
    endtask
    // Data set while clock low, held and sampled in the high phase
    task automatic bit_io(input logic b, output logic r);
        qtr;
        sda_oe_o <= ~b;
        qtr;
        scl_o <= 1'b1;
        qtr;
        r = sda_i;
        qtr;
        scl_o <= 1'b0;
    endtask
    // Eight bits msb first, then a released acknowledge slot
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // Receive a byte; acknowledge unless it is the last
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
    // Data rises with clock high
    task automatic stop;
        qtr;
        sda_oe_o <= 1'b1;
        qtr;
        scl_o <= 1'b1;
        qtr;
        sda_oe_o <= 1'b0;
        qtr;
    endtask
endmodule
